// >>> nau_core.sv
// nibble arithmetic unit: accumulator, carry and RAM address datapath
//
// Contract
// - Opcode 30 adds accumulator, carry and RAM nibble, stores sum and carry, and skips on carry-out.
// - Upper nibble 0101 adds the nonzero immediate to the accumulator only and skips on carry-out.
// - Opcode 40 inverts the accumulator, keeps carry and never skips.
// - Opcode 02 stores accumulator XOR RAM nibble in the accumulator without a skip.
// - Opcode 31 adds the RAM nibble ignoring carry, 00 zeroes the accumulator, 44 changes nothing, none skip.
// - Opcode 32 clears carry and 22 sets carry, both keep the accumulator and never skip.
// - The datapath holds a 4-bit accumulator and a separate one-bit carry.
// - The RAM address is 6 bits, upper 2 selecting the register and lower 4 the digit.
// - The memory operand is the RAM nibble at the current RAM address.
// - Reset clears accumulator, RAM address and carry and leaves RAM alone.
`timescale 1ns/1ps
module nau_core (
	input  wire logic                        core_clk,	// 20 MHz core clock
	input  wire logic                        sys_rst,	// sync reset, high
	input  wire logic                        instr_valid,	// execute op now
	input  wire logic [nau_pkg::NAU_OPW-1:0] instr_op,	// instruction byte
	input  wire logic                        addr_load,	// load RAM address
	input  wire logic [nau_pkg::NAU_AW-1:0]  addr_wdata,	// new RAM address
	input  wire logic [nau_pkg::NAU_DW-1:0]  ram_rdata,	// nibble at ram_addr
	output logic [nau_pkg::NAU_AW-1:0]       ram_addr,	// RAM address reg
	output logic [nau_pkg::NAU_RSW-1:0]      reg_select_bits,	// register sel
	output logic [nau_pkg::NAU_DW-1:0]       digit_select_bits,	// digit sel
	output logic [nau_pkg::NAU_DW-1:0]       acc_q,		// accumulator
	output logic                             carry_q,	// carry bit
	output logic                             skip_req	// skip next op
);
	import nau_pkg::*;

	// ==========================================================
	// state
	logic [NAU_DW-1:0] acc_ff;
	logic [NAU_DW-1:0] nxt_acc;
	logic              carry_ff;
	logic              nxt_carry;
	logic [NAU_AW-1:0] addr_ff;
	logic [NAU_AW-1:0] nxt_addr;
	logic              skip_ff;
	logic              nxt_skip;

	nau_op_t           op_class;
	logic [NAU_DW-1:0] op_imm;
	logic [NAU_DW:0]   sum_carry;	// five bits: carry-out on top
	logic [NAU_DW:0]   sum_plain;
	logic [NAU_DW:0]   sum_imm;

	// ==========================================================
	// decode
	nau_decode u_dec (
		.op_byte  (instr_op),
		.op_class (op_class),
		.op_imm   (op_imm)
	);

	// ==========================================================
	// adders are five bits so the top bit is the carry-out
	always_comb begin
		sum_carry = {1'b0, acc_ff} + {1'b0, ram_rdata}
			+ {{NAU_DW{1'b0}}, carry_ff};
		sum_plain = {1'b0, acc_ff} + {1'b0, ram_rdata};
		sum_imm   = {1'b0, acc_ff} + {1'b0, op_imm};
	end

	// ==========================================================
	// execute one instruction; ram_rdata is the nibble at addr_ff
	always_comb begin
		nxt_acc   = acc_ff;
		nxt_carry = carry_ff;
		nxt_skip  = 1'b0;	// skip is a one-cycle pulse per instruction
		if (instr_valid) begin
			unique case (op_class)
				NAU_OP_SUM_CARRY_SKIP: begin
					nxt_acc   = sum_carry[NAU_DW-1:0];
					nxt_carry = sum_carry[NAU_DW];
					nxt_skip  = sum_carry[NAU_DW];
				end
				NAU_OP_PLAIN_SUM: begin
					nxt_acc = sum_plain[NAU_DW-1:0];
				end
				NAU_OP_IMM_SUM_SKIP: begin
					// carry register untouched; only the skip sees carry-out
					nxt_acc  = sum_imm[NAU_DW-1:0];
					nxt_skip = sum_imm[NAU_DW];
				end
				NAU_OP_ZERO_ACC: begin
					nxt_acc = ACC_RST;
				end
				NAU_OP_COMPLEMENT: begin
					nxt_acc = ~acc_ff;
				end
				NAU_OP_IDLE: begin
					nxt_acc = acc_ff;
				end
				NAU_OP_CARRY_CLEAR: begin
					nxt_carry = 1'b0;
				end
				NAU_OP_CARRY_FORCE_ONE: begin
					nxt_carry = 1'b1;
				end
				NAU_OP_EXCL_OR: begin
					nxt_acc = acc_ff ^ ram_rdata;
				end
				NAU_OP_NONE: begin
					nxt_acc = acc_ff;
				end
			endcase
		end
	end

	// ==========================================================
	// RAM address: other instruction groups load it from outside
	always_comb begin
		nxt_addr = addr_ff;
		if (addr_load) begin
			nxt_addr = addr_wdata;
		end
	end

	// register the datapath; RAM has no reset path from here
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			acc_ff   <= ACC_RST;
			carry_ff <= CARRY_RST;
			addr_ff  <= ADDR_RST;
			skip_ff  <= SKIP_RST;
		end else begin
			acc_ff   <= nxt_acc;
			carry_ff <= nxt_carry;
			addr_ff  <= nxt_addr;
			skip_ff  <= nxt_skip;
		end
	end

	// ==========================================================
	// outputs straight from flops
	assign ram_addr          = addr_ff;
	assign reg_select_bits   = addr_ff[NAU_AW-1:NAU_REG_SEL_LSB];
	assign digit_select_bits = addr_ff[NAU_REG_SEL_LSB-1:NAU_DIG_SEL_LSB];
	assign acc_q             = acc_ff;
	assign carry_q           = carry_ff;
	assign skip_req          = skip_ff;

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// an issued instruction of a given class
	sequence s_issue(nau_op_t c);
		instr_valid && (op_class == c);
	endsequence

	sequence s_no_skip_after;
		##1 !skip_ff;
	endsequence

	// expected five-bit result of the carry add, taken at issue time
	logic [NAU_DW:0] exp_asc;
	assign exp_asc = {1'b0, acc_ff} + {1'b0, ram_rdata}
		+ {{NAU_DW{1'b0}}, carry_ff};

	property p_asc;
		s_issue(NAU_OP_SUM_CARRY_SKIP) |=>
			({carry_ff, acc_ff} == $past(exp_asc))
			&& (skip_ff == $past(exp_asc[NAU_DW]));
	endproperty
	asc_result_a: assert property (p_asc)
		else $error("carry add result, carry or skip wrong");

	imm_sum_a: assert property (
		s_issue(NAU_OP_IMM_SUM_SKIP) |=>
			(acc_ff == $past(acc_ff) + $past(instr_op[3:0]))
			&& (carry_ff == $past(carry_ff))
			&& (skip_ff == ({1'b0, $past(acc_ff)}
				+ {1'b0, $past(instr_op[3:0])} > 5'h0F)))
		else $error("immediate add wrong");

	imm_zero_a: assert property (
		instr_valid && (instr_op == 8'h50) |=>
			$stable(acc_ff) && $stable(carry_ff) && !skip_ff)
		else $error("zero immediate changed state");

	complement_a: assert property (
		s_issue(NAU_OP_COMPLEMENT) |=>
			(acc_ff == ~$past(acc_ff)) && $stable(carry_ff) && !skip_ff)
		else $error("complement wrong");

	excl_or_a: assert property (
		s_issue(NAU_OP_EXCL_OR) |=>
			(acc_ff == ($past(acc_ff) ^ $past(ram_rdata))) && !skip_ff)
		else $error("exclusive-or wrong");

	plain_sum_a: assert property (
		s_issue(NAU_OP_PLAIN_SUM) |=>
			(acc_ff == $past(acc_ff) + $past(ram_rdata))
			&& $stable(carry_ff) && !skip_ff)
		else $error("plain add wrong");

	zero_idle_a: assert property (
		(s_issue(NAU_OP_ZERO_ACC) |=> acc_ff == 4'h0 && !skip_ff)
		and (s_issue(NAU_OP_IDLE) |-> s_no_skip_after))
		else $error("clear or idle wrong");

	carry_ops_a: assert property (
		(s_issue(NAU_OP_CARRY_CLEAR) |=> !carry_ff && $stable(acc_ff))
		and (s_issue(NAU_OP_CARRY_FORCE_ONE) |=> carry_ff
			&& $stable(acc_ff) && !skip_ff))
		else $error("carry force wrong");

	addr_fields_a: assert property (
		addr_load |=> (ram_addr == $past(addr_wdata))
			&& ({reg_select_bits, digit_select_bits} == ram_addr))
		else $error("address split wrong");

	reset_clear_a: assert property (disable iff (1'b0)
		sys_rst |=> acc_q == 4'h0 && !carry_q && ram_addr == 6'h00
			&& !skip_req)
		else $error("reset did not clear");

	idle_hold_a: assert property (
		!instr_valid |=> $stable(acc_ff) && $stable(carry_ff) && !skip_ff)
		else $error("state moved without instruction");

endmodule

// >>> nau_core_test.sv
// self-checking bench for the nibble arithmetic unit
`timescale 1ns/1ps
module nau_core_test;
	import nau_pkg::*;

	logic                core_clk, sys_rst, instr_valid, addr_load;
	logic [NAU_OPW-1:0]  instr_op;
	logic [NAU_AW-1:0]   addr_wdata, ram_addr, m_addr;
	logic [NAU_DW-1:0]   ram_rdata, digit_select_bits, acc_q, m_acc;
	logic [NAU_RSW-1:0]  reg_select_bits;
	logic                carry_q, skip_req, m_c, drop, pend, chk;
	logic [11:0]         note;
	logic [11:0]         notes [$];
	logic [NAU_OPW-1:0]  op_tab [12];
	logic [NAU_OPW-1:0]  op;
	int                  seed, err_total, checks_done;

	nau_core DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.instr_valid(instr_valid), .instr_op(instr_op),
		.addr_load(addr_load), .addr_wdata(addr_wdata),
		.ram_rdata(ram_rdata), .ram_addr(ram_addr),
		.reg_select_bits(reg_select_bits),
		.digit_select_bits(digit_select_bits), .acc_q(acc_q),
		.carry_q(carry_q), .skip_req(skip_req));
	nau_ram_model ram (.ram_addr(ram_addr), .ram_rdata(ram_rdata));

	always #25 core_clk = ~core_clk;

	// ==========================================================
	// helpers
	function automatic logic [3:0] ram_val(logic [5:0] a);
		return a[3:0] + {a[5:4], 2'b11};
	endfunction

	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// one instruction slot; a slot after a skip is dropped, as a sequencer does
	task automatic exec(logic [7:0] opc);
		logic [4:0] s;
		logic       sk;
		logic       ld;
		logic [5:0] a;
		@(posedge core_clk);
		ld = ($random(seed) & 3) == 0;
		a = 6'($random(seed));
		addr_load <= ld;
		addr_wdata <= a;
		pend <= 1'b1;
		sk = 1'b0;
		if (drop) begin
			instr_valid <= 1'b0;
			drop = 1'b0;
		end else begin
			instr_valid <= 1'b1;
			instr_op <= opc;
			case (opc)
				OP_SUM_WITH_CARRY_SKIP: begin
					s = m_acc + m_c + ram_val(m_addr);
					m_acc = s[3:0];
					m_c = s[4];
					sk = s[4];
				end
				OP_PLAIN_SUM:       m_acc = m_acc + ram_val(m_addr);
				OP_ZERO_ACC:        m_acc = 4'h0;
				OP_COMPLEMENT:      m_acc = ~m_acc;
				OP_CARRY_CLEAR:     m_c = 1'b0;
				OP_CARRY_FORCE_ONE: m_c = 1'b1;
				OP_EXCL_OR:         m_acc = m_acc ^ ram_val(m_addr);
				default: ;
			endcase
			if (opc[7:4] == OP_IMM_SUM_HI && opc[3:0] != IMM_FORBIDDEN) begin
				s = m_acc + opc[3:0];
				m_acc = s[3:0];
				sk = s[4];
			end
			drop = sk;
		end
		// same-cycle instruction used the old address
		if (ld) m_addr = a;
		notes.push_back({m_acc, m_c, sk, m_addr});
	endtask

	task automatic idle();
		@(posedge core_clk);
		instr_valid <= 1'b0;
		addr_load <= 1'b0;
		pend <= 1'b0;
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		m_acc = ACC_RST;
		m_c = CARRY_RST;
		m_addr = ADDR_RST;
		drop = 1'b0;
		@(negedge core_clk);
		check("rst_acc", 8'(acc_q), 8'(ACC_RST));
		check("rst_carry", 8'(carry_q), 8'(CARRY_RST));
		check("rst_skip", 8'(skip_req), 8'(SKIP_RST));
		check("rst_addr", 8'(ram_addr), 8'(ADDR_RST));
		check("ram_kept", 8'(ram_rdata), 8'(ram_val(6'h00)));
	endtask

	// ==========================================================
	// result watcher: a note is due one cycle after each slot
	always @(posedge core_clk) chk <= pend & ~sys_rst;

	always @(negedge core_clk) begin
		if (chk && notes.size() > 0) begin
			note = notes.pop_front();
			check("acc", 8'(acc_q), 8'(note[11:8]));
			check("carry", 8'(carry_q), 8'(note[7]));
			check("skip", 8'(skip_req), 8'(note[6]));
			check("addr", 8'(ram_addr), 8'(note[5:0]));
			check("reg_sel", 8'(reg_select_bits), 8'(note[5:4]));
			check("dig_sel", 8'(digit_select_bits), 8'(note[3:0]));
		end
	end

	// watchdog, well past the few hundred slots of the run
	initial begin
		#200000;
		err_total++;
		test_done();
	end

	// ==========================================================
	// main sequence
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		instr_valid = 1'b0;
		instr_op = 8'h00;
		addr_load = 1'b0;
		addr_wdata = 6'h00;
		pend = 1'b0;
		chk = 1'b0;
		seed = 32'h1b6769dd;
		err_total = 0;
		checks_done = 0;
		// out-of-group bytes and the zero immediate must do nothing
		op_tab = '{OP_SUM_WITH_CARRY_SKIP, OP_PLAIN_SUM, OP_ZERO_ACC,
			OP_COMPLEMENT, OP_IDLE_OP, OP_CARRY_CLEAR, OP_CARRY_FORCE_ONE,
			OP_EXCL_OR, 8'h50, 8'hFF, 8'h48, 8'h5F};
		do_reset();
		// boundary: F plus carry plus nibble always carries out, then skips
		exec(OP_CARRY_FORCE_ONE);
		exec(OP_ZERO_ACC);
		exec(OP_COMPLEMENT);
		exec(OP_SUM_WITH_CARRY_SKIP);
		exec(OP_IDLE_OP);
		foreach (op_tab[i]) exec(op_tab[i]);
		for (int y = 0; y < 16; y++) exec({OP_IMM_SUM_HI, 4'(y)});
		for (int n = 0; n < 300; n++) begin
			op = op_tab[$unsigned($random(seed)) % 12];
			if (op == 8'h5F) op[3:0] = 4'($random(seed));
			exec(op);
		end
		idle();
		do_reset();
		for (int n = 0; n < 20; n++) exec(op_tab[n % 12]);
		idle();
		idle();
		test_done();
	end
endmodule

// >>> nau_decode.sv
// opcode decoder for the nibble arithmetic unit
`timescale 1ns/1ps
module nau_decode (
	input  wire logic [nau_pkg::NAU_OPW-1:0] op_byte,	// instruction byte
	output nau_pkg::nau_op_t                 op_class,	// decoded class
	output logic [nau_pkg::NAU_DW-1:0]       op_imm		// immediate nibble
);
	import nau_pkg::*;

	// ==========================================================
	// classify one byte; bytes outside the group decode to none
	function automatic nau_op_t classify(input logic [7:0] b);
		nau_op_t c;
		c = NAU_OP_NONE;
		if (b[7:4] == OP_IMM_SUM_HI) begin
			// a zero immediate is not a valid encoding, so it does nothing
			if (b[3:0] != IMM_FORBIDDEN) begin
				c = NAU_OP_IMM_SUM_SKIP;
			end
		end else begin
			unique case (b)
				OP_SUM_WITH_CARRY_SKIP: c = NAU_OP_SUM_CARRY_SKIP;
				OP_PLAIN_SUM:           c = NAU_OP_PLAIN_SUM;
				OP_ZERO_ACC:            c = NAU_OP_ZERO_ACC;
				OP_COMPLEMENT:          c = NAU_OP_COMPLEMENT;
				OP_IDLE_OP:             c = NAU_OP_IDLE;
				OP_CARRY_CLEAR:         c = NAU_OP_CARRY_CLEAR;
				OP_CARRY_FORCE_ONE:     c = NAU_OP_CARRY_FORCE_ONE;
				OP_EXCL_OR:             c = NAU_OP_EXCL_OR;
				default:                c = NAU_OP_NONE;
			endcase
		end
		return c;
	endfunction

	// decode and immediate split
	always_comb begin
		op_class = classify(op_byte);
		op_imm   = op_byte[3:0];
	end

endmodule

// >>> nau_pkg.sv
// constants and types shared by the nibble arithmetic unit files
package nau_pkg;

	// ==========================================================
	// datapath widths
	localparam int NAU_DW   = 4;	// accumulator and RAM nibble
	localparam int NAU_AW   = 6;	// RAM address register
	localparam int NAU_RSW  = 2;	// register select field
	localparam int NAU_OPW  = 8;	// instruction byte

	// ==========================================================
	// field positions inside the RAM address register
	localparam int NAU_REG_SEL_LSB = 4;
	localparam int NAU_DIG_SEL_LSB = 0;

	// ==========================================================
	// opcodes of the arithmetic group
	localparam logic [7:0] OP_SUM_WITH_CARRY_SKIP = 8'h30;
	localparam logic [7:0] OP_PLAIN_SUM           = 8'h31;
	localparam logic [7:0] OP_ZERO_ACC            = 8'h00;
	localparam logic [7:0] OP_COMPLEMENT          = 8'h40;
	localparam logic [7:0] OP_IDLE_OP             = 8'h44;
	localparam logic [7:0] OP_CARRY_CLEAR         = 8'h32;
	localparam logic [7:0] OP_CARRY_FORCE_ONE     = 8'h22;
	localparam logic [7:0] OP_EXCL_OR             = 8'h02;
	localparam logic [3:0] OP_IMM_SUM_HI          = 4'h5;
	localparam logic [3:0] IMM_FORBIDDEN          = 4'h0;

	// ==========================================================
	// values after reset
	localparam logic [3:0] ACC_RST   = 4'h0;
	localparam logic       CARRY_RST = 1'b0;
	localparam logic [5:0] ADDR_RST  = 6'h00;
	localparam logic       SKIP_RST  = 1'b0;

	// ==========================================================
	// decoded operation classes
	typedef enum logic [3:0] {
		NAU_OP_NONE,
		NAU_OP_SUM_CARRY_SKIP,
		NAU_OP_PLAIN_SUM,
		NAU_OP_IMM_SUM_SKIP,
		NAU_OP_ZERO_ACC,
		NAU_OP_COMPLEMENT,
		NAU_OP_IDLE,
		NAU_OP_CARRY_CLEAR,
		NAU_OP_CARRY_FORCE_ONE,
		NAU_OP_EXCL_OR
	} nau_op_t;

endpackage

// >>> nau_ram_model.sv
// data RAM model that answers the nibble reads of the arithmetic unit
`timescale 1ns/1ps
module nau_ram_model (
	input  wire logic [nau_pkg::NAU_AW-1:0] ram_addr,	// nibble address
	output logic [nau_pkg::NAU_DW-1:0]      ram_rdata	// nibble at address
);
	import nau_pkg::*;

	// ==========================================================
	// storage
	logic [NAU_DW-1:0] mem [64];

	// fixed pattern, never cleared by reset, so a clear shows up
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 4'(i) + {2'(i >> 4), 2'b11};
		end
	end

	// asynchronous read at the address that the unit holds
	assign ram_rdata = mem[ram_addr];
endmodule
